/* File: hw/adcbr_pkg.sv */
// Contract
// RL1: Bus access only while high select is high and low select is low.
// RL2: Direction high reads selected register, low writes host data into it.
// RL3: Data drivers stay off except during a host read addressed to us.
// RL4: Host qualifies every read or write with the bus strobe.
// RL5: Two select lines decode control, command, status and result/compare.
// RL6: Status: irq bit7, active bit6, compare bit5, over bit3, weight bit2.
// RL7: Address 3 reads lower result, writes compare value; neither crosses.
// RL8: Control: irq enable 7, halve 6, settling 5, gain mode 1..0.
// RL9: Reset low clears shift registers and aborts any conversion.
// RL10: Reset forces gain output low, interrupt off, data bus off.
// RL11: Reset leaves the interrupt enable bit unchanged.
// RL12: Interrupt pin low when enabled and flag sets at conversion end.
// RL13: Interrupt released right after host reads lower result.
// RL14: Comparison completion never touches the interrupt.
// RL15: Four-bit channel address of command selects one of sixteen inputs.
// RL16: Gain mode bits choose the gain output behaviour.
// RL17: Conversion steps are timed by conversion clock, not bus strobe.
// RL18: Each command write starts the selected conversion or comparison.
// RL19: Active bit reads one during conversion, zero after completion.
// RL20: Short cycle clears upper result bits, full byte in lower result.
// RL21: Writes captured at end of strobe high phase, once per cycle.
// RL22: Reads have no side effect except interrupt clear on lower result.
package adcbr_pkg;
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_CMD = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [1:0] ADDR_RESULT = 2'h3;

    localparam int CTRL_IE = 7;
    localparam int CTRL_CD = 6;
    localparam int CTRL_ST = 5;

    localparam int CMD_SC = 7;
    localparam int CMD_GS = 6;
    localparam int CMD_PC = 5;
    localparam int CMD_MI = 4;

    localparam logic [1:0] GAIN_SAMPLE_HOLD = 2'h0;
    localparam logic [1:0] GAIN_AUTO_X2 = 2'h1;
    localparam logic [1:0] GAIN_AUTO_X4 = 2'h2;
    localparam logic [1:0] GAIN_PROGRAMMED = 2'h3;

    localparam int SAR_BITS = 10;
    localparam logic [3:0] SAR_MSB = 4'h9;
    localparam logic [3:0] SAR_LSB_FULL = 4'h0;
    localparam logic [3:0] SAR_LSB_SHORT = 4'h2;
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
    localparam logic [9:0] SAR_FULL_SCALE = 10'h3FF;
    localparam logic [7:0] SHORT_FULL_SCALE = 8'hFF;
    localparam logic [9:0] DW_LIMIT_X2 = 10'h19A;
    localparam logic [9:0] DW_LIMIT_X4 = 10'h0CE;

    localparam int SYNC_W = 17;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SETTLE,
        SEQ_TRIAL
    } adcbr_seq_e;
endpackage

/* File: hw/adcbr_sync.sv */
`timescale 1ns/1ps
module adcbr_sync #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

/* File: hw/adcbr_top.sv */
`timescale 1ns/1ps
module adcbr_top (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic bus_strobe_i,
    input wire logic select_active_high_i,
    input wire logic select_active_low_n_i,
    input wire logic read_write_i,
    input wire logic reg_select_hi_i,
    input wire logic reg_select_lo_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic irq_o,
    output logic irq_oe_o,
    input wire logic chip_reset_n_i,
    input wire logic conv_clock_i,
    input wire logic comparator_input_i,
    output logic [adcbr_pkg::SAR_BITS-1:0] dac_code_o,
    output logic [3:0] channel_address_o,
    output logic mux_inhibit_o,
    output logic gain_control_out_o
);
    import adcbr_pkg::*;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic e_s;
    logic e_d;
    logic sel_s;
    logic rw_s;
    logic [1:0] addr_s;
    logic [7:0] wdata_s;
    logic creset_n_s;
    logic ck_s;
    logic ck_d;
    logic comp_s;

    assign pins_raw = {bus_strobe_i,
                       select_active_high_i,
                       select_active_low_n_i,
                       read_write_i,
                       reg_select_hi_i,
                       reg_select_lo_i,
                       data_i,
                       chip_reset_n_i,
                       conv_clock_i,
                       comparator_input_i};

    // Every pin crosses into the system clock before use
    adcbr_sync #(
        .W(SYNC_W)
    ) u_pin_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    assign e_s = pins_s[16];
    assign sel_s = pins_s[15] & ~pins_s[14]; // [RL1]
    assign rw_s = pins_s[13];
    assign addr_s = pins_s[12:11];
    assign wdata_s = pins_s[10:3];
    assign creset_n_s = pins_s[2];
    assign ck_s = pins_s[1];
    assign comp_s = pins_s[0];

    logic creset;
    assign creset = ~creset_n_s;

    // Bus cycle capture
    logic lat_sel;
    logic lat_rw;
    logic [1:0] lat_addr;
    logic [7:0] lat_data;
    logic e_fall;
    logic wr_stb;
    logic rd_result;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            e_d <= 1'b0;
            ck_d <= 1'b0;
        end else begin
            e_d <= e_s;
            ck_d <= ck_s;
        end
    end

    // Track the last strobe-high sample; hold time is too short to use
    // the values seen after the falling edge.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lat_sel <= 1'b0;
            lat_rw <= 1'b1;
            lat_addr <= 2'h0;
            lat_data <= 8'h00;
        end else if (e_s) begin // [RL4]
            lat_sel <= sel_s;
            lat_rw <= rw_s;
            lat_addr <= addr_s;
            lat_data <= wdata_s;
        end
    end

    assign e_fall = e_d & ~e_s;
    // One write per bus cycle, at end of strobe high
    assign wr_stb = e_fall & lat_sel & ~lat_rw & ~creset; // [RL21] [RL2]
    // Only a read of the lower result has a side effect
    assign rd_result = e_fall & lat_sel & lat_rw & ~creset
                       & (lat_addr == ADDR_RESULT); // [RL22]

    // Register file
    logic ie;
    logic cd;
    logic st;
    logic [1:0] gmode;
    logic [7:0] cmd;
    logic [7:0] cmp_val;

    // Enable survives the chip reset pin; only power-on clears it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ie <= CTRL_RESET[CTRL_IE];
        end else if (wr_stb && lat_addr == ADDR_CTRL) begin // [RL11]
            ie <= lat_data[CTRL_IE]; // [RL8]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cd <= CTRL_RESET[CTRL_CD];
            st <= CTRL_RESET[CTRL_ST];
            gmode <= CTRL_RESET[1:0];
        end else if (creset) begin // [RL9]
            cd <= CTRL_RESET[CTRL_CD];
            st <= CTRL_RESET[CTRL_ST];
            gmode <= CTRL_RESET[1:0];
        end else if (wr_stb && lat_addr == ADDR_CTRL) begin // [RL5]
            cd <= lat_data[CTRL_CD]; // [RL8]
            st <= lat_data[CTRL_ST];
            gmode <= lat_data[1:0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd <= CMD_RESET;
        end else if (creset) begin
            cmd <= CMD_RESET;
        end else if (wr_stb && lat_addr == ADDR_CMD) begin
            cmd <= lat_data;
        end
    end

    // Compare value is write-only at the shared slot
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_val <= CMP_RESET;
        end else if (creset) begin
            cmp_val <= CMP_RESET;
        end else if (wr_stb && lat_addr == ADDR_RESULT) begin // [RL7]
            cmp_val <= lat_data;
        end
    end

    logic sc;
    logic gs;
    logic pc;
    assign sc = cmd[CMD_SC];
    assign gs = cmd[CMD_GS];
    assign pc = cmd[CMD_PC];

    // Conversion clock edges, optionally halved
    logic half;
    logic ck_rise;
    logic tick;
    assign ck_rise = ck_s & ~ck_d;
    assign tick = ck_rise & (~cd | half); // [RL17]

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half <= 1'b0;
        end else if (creset) begin
            half <= 1'b0;
        end else if (ck_rise) begin
            half <= ~half;
        end
    end

    // Successive approximation sequencer
    adcbr_seq_e state;
    logic [3:0] bit_idx;
    logic [9:0] dac;
    logic [9:0] kept;
    logic [3:0] last_idx;
    logic busy;
    logic start;
    logic finish;
    logic cmp_done;
    logic extra_wait;

    assign start = wr_stb && lat_addr == ADDR_CMD; // [RL18]
    assign last_idx = sc ? SAR_LSB_SHORT : SAR_LSB_FULL;

    always_comb begin
        kept = dac;
        kept[bit_idx] = comp_s;
    end

    assign finish = state == SEQ_TRIAL && tick && !pc && !start
                    && bit_idx == last_idx;
    assign cmp_done = state == SEQ_TRIAL && tick && pc && !start;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= SEQ_IDLE;
            bit_idx <= SAR_MSB;
            dac <= '0;
            extra_wait <= 1'b0;
        end else if (creset) begin // [RL9]
            state <= SEQ_IDLE;
            bit_idx <= SAR_MSB;
            dac <= '0;
            extra_wait <= 1'b0;
        end else if (start) begin
            // First tick only carries the new trial through the comparator
            // synchroniser; deciding on it would use a stale comparison
            state <= SEQ_SETTLE;
            extra_wait <= st;
            bit_idx <= SAR_MSB;
            dac <= lat_data[CMD_PC] ? {cmp_val, 2'b00} : SAR_FIRST_TRIAL;
        end else begin
            case (state)
                SEQ_IDLE: begin
                    state <= SEQ_IDLE;
                end
                SEQ_SETTLE: begin
                    if (tick && extra_wait) begin
                        extra_wait <= 1'b0;
                    end else if (tick) begin
                        state <= SEQ_TRIAL;
                    end
                end
                SEQ_TRIAL: begin
                    if (tick) begin // [RL17]
                        if (pc || bit_idx == last_idx) begin
                            state <= SEQ_IDLE;
                            dac <= pc ? dac : kept;
                        end else begin
                            dac <= kept | (10'h001 << (bit_idx - 4'h1));
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Status and result
    logic irq_flag;
    logic compare_result;
    logic ov;
    logic dw;
    logic [1:0] res_hi;
    logic [7:0] res_lo;
    logic next_dw;

    always_comb begin
        next_dw = 1'b0;
        if (gs) begin
            case (gmode)
                GAIN_AUTO_X2: next_dw = kept < DW_LIMIT_X2;
                GAIN_AUTO_X4: next_dw = kept < DW_LIMIT_X4;
                GAIN_PROGRAMMED: next_dw = 1'b1;
                default: next_dw = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
        end else if (creset) begin
            busy <= 1'b0;
        end else if (start) begin
            busy <= 1'b1; // [RL19]
        end else if (finish || cmp_done) begin
            busy <= 1'b0; // [RL19]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_hi <= 2'h0;
            res_lo <= 8'h00;
            ov <= 1'b0;
            dw <= 1'b0;
        end else if (creset) begin
            res_hi <= 2'h0;
            res_lo <= 8'h00;
            ov <= 1'b0;
            dw <= 1'b0;
        end else if (finish) begin
            if (sc) begin
                res_hi <= 2'h0; // [RL20]
                res_lo <= kept[9:2];
                ov <= kept[9:2] == SHORT_FULL_SCALE;
            end else begin
                res_hi <= kept[9:8];
                res_lo <= kept[7:0];
                ov <= kept == SAR_FULL_SCALE;
            end
            dw <= next_dw;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            compare_result <= 1'b0;
        end else if (creset) begin
            compare_result <= 1'b0;
        end else if (cmp_done) begin
            compare_result <= comp_s;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_flag <= 1'b0;
        end else if (creset) begin
            irq_flag <= 1'b0;
        end else if (finish) begin
            irq_flag <= 1'b1; // [RL12] [RL14]
        end else if (rd_result) begin
            irq_flag <= 1'b0; // [RL13]
        end
    end

    logic [7:0] status_val;
    assign status_val = {irq_flag, busy, compare_result, 1'b0, ov, dw, res_hi}; // [RL6]

    // Bus read path
    logic [7:0] next_rdata;
    always_comb begin
        case (addr_s) // [RL5]
            ADDR_CTRL: next_rdata = {ie, cd, st, 3'b000, gmode};
            ADDR_CMD: next_rdata = cmd;
            ADDR_STATUS: next_rdata = status_val;
            ADDR_RESULT: next_rdata = res_lo; // [RL7]
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_o <= next_rdata;
            data_oe_o <= e_s & sel_s & rw_s & ~creset; // [RL3] [RL2] [RL10]
        end
    end

    // Pins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
            irq_oe_o <= 1'b0;
            gain_control_out_o <= 1'b0;
            dac_code_o <= '0;
            channel_address_o <= 4'h0;
            mux_inhibit_o <= 1'b0;
        end else begin
            irq_o <= 1'b0;
            irq_oe_o <= ie & irq_flag & ~creset; // [RL12] [RL10]
            dac_code_o <= dac;
            channel_address_o <= cmd[3:0]; // [RL15]
            mux_inhibit_o <= cmd[CMD_MI];
            if (creset || !gs || pc) begin
                gain_control_out_o <= 1'b0; // [RL10]
            end else begin
                case (gmode) // [RL16]
                    GAIN_SAMPLE_HOLD: gain_control_out_o <= busy;
                    GAIN_PROGRAMMED: gain_control_out_o <= 1'b1;
                    default: gain_control_out_o <= dw;
                endcase
            end
        end
    end

    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_conv_end;
        finish && ie;
    endsequence

    sequence s_result_read;
        rd_result && !finish;
    endsequence

    a_irq_raise_pin: assert property (s_conv_end |-> ##2 irq_oe_o) // [RL12]
        else $error("interrupt pin not driven after conversion end");
    a_irq_release_read: assert property (s_result_read |-> ##2 !irq_oe_o) // [RL13]
        else $error("interrupt pin not released after result read");
    a_compare_no_irq: assert property (cmp_done && !irq_flag |=> !irq_flag) // [RL14]
        else $error("comparison raised interrupt flag");
    a_bus_read_only: assert property (data_oe_o |-> $past(e_s && sel_s && rw_s)) // [RL3]
        else $error("data bus driven outside a read cycle");
    a_reset_pins_off: assert property (creset [*2] |-> !gain_control_out_o && !irq_oe_o && !data_oe_o) // [RL10]
        else $error("outputs active during chip reset");
    a_reset_keeps_ie: assert property (creset |=> $stable(ie)) // [RL11]
        else $error("interrupt enable changed by chip reset");
    a_reset_aborts: assert property (creset |=> state == SEQ_IDLE && !busy) // [RL9]
        else $error("conversion survived chip reset");
    a_cmd_starts: assert property (start |=> busy && state != SEQ_IDLE) // [RL18]
        else $error("command write did not start conversion");
    a_busy_clears: assert property (finish |=> !busy ##1 !status_val[6]) // [RL19]
        else $error("active bit still set after completion");
    a_short_upper: assert property (finish && sc |=> res_hi == 2'h0) // [RL20]
        else $error("short cycle left upper result bits");
    a_write_ctrl: assert property (wr_stb && lat_addr == ADDR_CTRL |=> gmode == $past(lat_data[1:0])) // [RL21]
        else $error("control write not captured");
    a_trial_on_tick: assert property ( // [RL17]
        state == SEQ_TRIAL && !tick && !start && !creset |=> $stable(dac))
        else $error("trial step taken without a conversion clock tick");
endmodule

/* File: verif/adcbr_analog_model.sv */
`timescale 1ns/1ps
module adcbr_analog_model (
    input wire logic [9:0] dac_code_i,
    input wire logic [3:0] channel_i,
    input wire logic inhibit_i,
    output logic comparator_o
);
    logic [9:0] level [16];
    logic [9:0] sel_level;

    initial begin
        for (int i = 0; i < 16; i++) begin
            level[i] = 10'h000;
        end
    end

    // No external mux fitted, so an inhibited channel reads ground
    assign sel_level = inhibit_i ? 10'h000 : level[channel_i];
    // Half-LSB offset: a trial equal to the level is kept by the search
    assign comparator_o = {sel_level, 1'b1} > {dac_code_i, 1'b0};
endmodule

/* File: verif/tb_adcbr_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("unexpected at %0t: got %h want %h", $time, g, e); \
        end \
    end

module tb_adcbr_top;
    import adcbr_pkg::*;
    logic clock, rst_n, strobe, sel_hi, sel_lo_n, rnw, rs_hi, rs_lo;
    logic chip_reset_n, conv_clock, comp;
    logic [7:0] host_data, data_out, v;
    wire logic [7:0] data_pin;
    logic data_oe, irq, irq_oe, mux_inh, gain;
    logic [9:0] dac;
    logic [3:0] chan;
    int n_mismatch, n_checks, cycles;

    // Released host lines show a changing pattern, not the last value
    assign data_pin = data_oe ? data_out : host_data;
    wire logic irq_pin_n = irq_oe ? irq : 1'b1;

    adcbr_top u_dut (
        .clock_i(clock), .rst_n_i(rst_n), .bus_strobe_i(strobe),
        .select_active_high_i(sel_hi), .select_active_low_n_i(sel_lo_n),
        .read_write_i(rnw), .reg_select_hi_i(rs_hi),
        .reg_select_lo_i(rs_lo), .data_i(data_pin), .data_o(data_out),
        .data_oe_o(data_oe), .irq_o(irq), .irq_oe_o(irq_oe),
        .chip_reset_n_i(chip_reset_n), .conv_clock_i(conv_clock),
        .comparator_input_i(comp), .dac_code_o(dac),
        .channel_address_o(chan), .mux_inhibit_o(mux_inh),
        .gain_control_out_o(gain)
    );

    adcbr_analog_model u_ana (
        .dac_code_i(dac), .channel_i(chan), .inhibit_i(mux_inh),
        .comparator_o(comp)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        conv_clock = 1'b0;
        #37;
        forever #200 conv_clock = ~conv_clock;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("unexpected at %0t: run timed out", $time);
            tally_and_finish;
        end
    end

    // One full bus cycle: strobe high 10 clocks, low 10 clocks
    task automatic bus(input logic rd, input logic [1:0] slot,
                       input logic [7:0] wd, input logic [1:0] sel,
                       output logic [7:0] rdat);
        @(posedge clock);
        #1;
        {sel_hi, sel_lo_n} = sel;
        rnw = rd;
        {rs_hi, rs_lo} = slot;
        host_data = rd ? ~host_data : wd;
        strobe = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        rdat = data_pin;
        `CHK(data_oe, rd & (sel == 2'b10))
        strobe = 1'b0;
        repeat (10) @(posedge clock);
        #1;
        {sel_hi, sel_lo_n} = 2'b01;
        host_data = ~host_data;
    endtask

    task automatic wr(input logic [1:0] slot, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b0, slot, d, 2'b10, r);
    endtask

    task automatic rd_chk(input logic [1:0] slot, input logic [7:0] mask,
                          input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b1, slot, 8'h00, 2'b10, r);
        `CHK(r & mask, exp)
    endtask

    // Polls the active bit; bounded so a stuck converter cannot hang us
    task automatic wait_done;
        logic [7:0] r;
        int n;
        n = 0;
        r = 8'h40;
        while (r[6] !== 1'b0 && n < 40) begin
            bus(1'b1, ADDR_STATUS, 8'h00, 2'b10, r);
            n++;
        end
        `CHK(r[6], 1'b0)
    endtask

    task automatic conv(input logic [7:0] ctrl, input logic [7:0] cmd,
                        input logic [9:0] lvl, input logic [7:0] stat,
                        input logic [7:0] low, input logic gexp);
        u_ana.level[cmd[3:0]] = lvl;
        wr(ADDR_CTRL, ctrl);
        wr(ADDR_CMD, cmd);
        `CHK({mux_inh, chan}, cmd[4:0])
        rd_chk(ADDR_STATUS, 8'h40, 8'h40);
        rd_chk(ADDR_CMD, 8'hFF, cmd);
        wait_done;
        rd_chk(ADDR_STATUS, 8'hDF, stat);
        `CHK(irq_pin_n, ~ctrl[7])
        `CHK(gain, gexp)
        rd_chk(ADDR_RESULT, 8'hFF, low);
        `CHK(irq_pin_n, 1'b1)
        rd_chk(ADDR_STATUS, 8'h80, 8'h00);
    endtask

    initial begin
        n_mismatch = 0;
        n_checks = 0;
        cycles = 0;
        rst_n = 1'b0;
        strobe = 1'b0;
        {sel_hi, sel_lo_n, rnw, rs_hi, rs_lo} = 5'b01100;
        host_data = 8'h00;
        chip_reset_n = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHK({gain, irq_pin_n, data_oe}, 3'b010)
        rd_chk(ADDR_CTRL, 8'hFF, 8'h00);
        rd_chk(ADDR_STATUS, 8'hDF, 8'h00);
        wr(ADDR_CTRL, 8'hFF);
        rd_chk(ADDR_CTRL, 8'hFF, 8'hE3);
        bus(1'b0, ADDR_CTRL, 8'h00, 2'b00, v);
        bus(1'b0, ADDR_CTRL, 8'h00, 2'b11, v);
        bus(1'b1, ADDR_CTRL, 8'h00, 2'b11, v);
        rd_chk(ADDR_CTRL, 8'hFF, 8'hE3);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_STATUS, 8'hFF);
        rd_chk(ADDR_STATUS, 8'hDF, 8'h00);
        wr(ADDR_RESULT, 8'hA5);
        rd_chk(ADDR_RESULT, 8'hFF, 8'h00);
        conv(8'h80, 8'h05, 10'h2B7, 8'h82, 8'hB7, 1'b0);
        conv(8'h01, 8'hC9, 10'h0FC, 8'h84, 8'h3F, 1'b1);
        conv(8'h62, 8'h4F, 10'h3FF, 8'h8B, 8'hFF, 1'b0);
        conv(8'h03, 8'h5F, 10'h3FF, 8'h84, 8'h00, 1'b1);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, 8'h80);
            wr(ADDR_RESULT, (i == 0) ? 8'h80 : 8'hC0);
            wr(ADDR_CMD, 8'h25);
            wait_done;
            rd_chk(ADDR_STATUS, 8'hA0, (i == 0) ? 8'h20 : 8'h00);
            `CHK(irq_pin_n, 1'b1)
        end
        // Chip reset in mid-conversion with sample-hold gain output
        wr(ADDR_CTRL, 8'h80);
        wr(ADDR_CMD, 8'h45);
        `CHK(gain, 1'b1)
        @(posedge clock);
        #1;
        chip_reset_n = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        `CHK({gain, irq_pin_n, data_oe}, 3'b010)
        chip_reset_n = 1'b1;
        // Longer than any conversion, so a surviving one would finish
        repeat (200) @(posedge clock);
        rd_chk(ADDR_STATUS, 8'hDF, 8'h00);
        `CHK(irq_pin_n, 1'b1)
        rd_chk(ADDR_CTRL, 8'hFF, 8'h80);
        tally_and_finish;
    end
endmodule
